// File: logic/onchip_address_decoder.sv
// Purpose: Steers each core access outside the reserved area to flash, flash registers, extension
//          RAM, expansion peripherals or the external interface.
// Assumes: Request inputs come from same-clock core logic.
// Notes:   Answer is registered, one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
`include "addr_decoder_cfg.svh"

module onchip_address_decoder
   import addr_decoder_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        req_valid_in,
   input  wire logic [23:0] addr_in,
   input  wire logic        write_in,
   input  wire logic        byte_in,
   input  wire logic        fetch_in,
   input  wire logic        bootstrap_mode_in,
   input  wire logic        segment_remap_bit_in,
   input  wire logic        global_expansion_enable_in,
   input  wire logic [15:0] expansion_periph_control_in,
   input  wire logic        large_ram_base_we_in,
   input  wire logic [9:0]  large_ram_base_select_in,
   output logic             resp_valid_out,
   output var target_t      target_out,
   output logic [2:0]       sector_out,
   output logic [17:0]      offset_out,
   output logic             width32_out,
   output logic [1:0]       wait_states_out,
   output logic [4:0]       access_cycles_out,
   output logic             refused_out,
   output logic [7:0]       periph_sel_out,
   output logic [10:0]      occupied_out,
   output logic [9:0]       large_ram_base_out,
   output logic [3:0]       seg_lines_out
);

   localparam logic [4:0] PERIPH_CYCLES = 5'(`CFG_PERIPH_CYCLES);

   state_t s_q;
   state_t s_d;

   // Peripheral page table, indexed like periph_sel_out
   logic [7:0][15:0] page_tab;
   logic [7:0][3:0]  bit_tab;
   assign page_tab = {16'(`CFG_PG_MISC),
                      16'(`CFG_PG_I2C),
                      16'(`CFG_PG_SYNC),
                      16'(`CFG_PG_ASYNC),
                      16'(`CFG_PG_PWM),
                      16'(`CFG_PG_RTC),
                      16'(`CFG_PG_MSG2),
                      16'(`CFG_PG_MSG1)};
   assign bit_tab = {4'(`CFG_BIT_MISC), 4'(`CFG_BIT_I2C),
                     4'(`CFG_BIT_SYNC), 4'(`CFG_BIT_ASYNC),
                     4'(`CFG_BIT_PWM), 4'(`CFG_BIT_RTC),
                     4'(`CFG_BIT_MSG2), 4'(`CFG_BIT_MSG1)};

   logic [7:0] periph_hit;

   // Live enables; occ_q only holds what was set at the global rise
   logic [10:0] occ_live;
   assign occ_live = s_q.glb_q ? s_q.occ_q : 11'h000;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_periph
         range_match u_match
         (
            .addr_in   (addr_in),
            .lo_in     ({page_tab[gi], 8'h00}),
            .hi_in     ({page_tab[gi], 8'hFF}),
            .enable_in (occ_live[bit_tab[gi]]),
            .hit_out   (periph_hit[gi])
         );
      end
   endgenerate

   logic        alt_map;
   logic        fl_hit;
   logic        fl_test_hit;
   logic [2:0]  fl_sector;
   logic [17:0] fl_offset;

   // Program and erase both arrive as write accesses
   assign alt_map = write_in || segment_remap_bit_in;

   flash_sector_map u_flash
   (
      .addr_in      (addr_in),
      .alt_map_in   (alt_map),
      .boot_in      (bootstrap_mode_in),
      .fetch_in     (fetch_in),
      .hit_out      (fl_hit),
      .test_hit_out (fl_test_hit),
      .sector_out   (fl_sector),
      .offset_out   (fl_offset)
   );

   logic sram_hit;
   logic lram_hit;
   assign sram_hit = occ_live[`CFG_BIT_SRAM]
                     && addr_in >= `CFG_SRAM_LO
                     && addr_in <= `CFG_SRAM_HI;
   // Window is 16K aligned; contents repeat inside it by size
   assign lram_hit = occ_live[`CFG_BIT_LRAM]
                     && addr_in[23:14] == s_q.lram_base_q;

   always_comb
   begin
      s_d = s_q;
      s_d.glb_q = global_expansion_enable_in;
      // Capture enables only on the global rise; later changes are ignored
      if (global_expansion_enable_in && !s_q.glb_q)
         s_d.occ_q = expansion_periph_control_in[10:0];
      // Cleared with the global enable so the output needs no gate
      if (!global_expansion_enable_in)
         s_d.occ_q = 11'h000;
      if (large_ram_base_we_in)
         s_d.lram_base_q = large_ram_base_select_in;
      s_d.seg_lines_q = (occ_live[`CFG_BIT_MSG1] || occ_live[`CFG_BIT_MSG2])
                        ? `CFG_SEG_LINES_MSG
                        : `CFG_SEG_LINES_FULL;
      s_d.valid_q = req_valid_in;
      if (req_valid_in)
      begin
         s_d.target_q = TGT_EXTERNAL;
         s_d.sector_q = 3'h0;
         s_d.offset_q = addr_in[17:0];
         s_d.width32_q = 1'b0;
         s_d.wait_q = 2'h0;
         s_d.cycles_q = 5'h01;
         s_d.refused_q = 1'b0;
         s_d.psel_q = 8'h00;
         if (fl_test_hit)
         begin
            s_d.target_q = TGT_TEST_FLASH;
            s_d.offset_q = fl_offset;
            s_d.width32_q = fetch_in;
            // Software has no write path into the test sector
            s_d.refused_q = write_in;
         end
         else if (fl_hit)
         begin
            s_d.target_q = TGT_FLASH;
            s_d.sector_q = fl_sector;
            s_d.offset_q = fl_offset;
            s_d.width32_q = fetch_in;
         end
         else if (addr_in >= `CFG_RSVD_LO && addr_in <= `CFG_RSVD_HI)
         begin
            s_d.target_q = TGT_RESERVED;
            s_d.refused_q = 1'b1;
         end
         else if (addr_in >= `CFG_FREG_LO && addr_in <= `CFG_FREG_HI)
         begin
            s_d.target_q = TGT_FLASH_REGS;
            s_d.offset_q = {2'h0, addr_in[15:0]};
         end
         else if (sram_hit)
         begin
            s_d.target_q = TGT_SMALL_RAM;
            s_d.offset_q = {7'h00, addr_in[10:0]};
         end
         else if (lram_hit)
         begin
            s_d.target_q = TGT_LARGE_RAM;
            s_d.offset_q = LARGE_VARIANT ? {4'h0, addr_in[13:0]}
                                         : {5'h00, addr_in[12:0]};
         end
         else if (|periph_hit)
         begin
            s_d.target_q = TGT_PERIPH;
            s_d.psel_q = periph_hit;
            s_d.wait_q = `CFG_PERIPH_WAIT;
            s_d.cycles_q = PERIPH_CYCLES;
            s_d.refused_q = byte_in;
            s_d.offset_q = {10'h000, addr_in[7:0]};
         end
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
         s_q.target_q <= TGT_NONE;
         s_q.lram_base_q <= `CFG_LRAM_BASE_RST;
         s_q.seg_lines_q <= `CFG_SEG_LINES_FULL;
      end
      else
         s_q <= s_d;
   end

   assign resp_valid_out     = s_q.valid_q;
   assign target_out         = s_q.target_q;
   assign sector_out         = s_q.sector_q;
   assign offset_out         = s_q.offset_q;
   assign width32_out        = s_q.width32_q;
   assign wait_states_out    = s_q.wait_q;
   assign access_cycles_out  = s_q.cycles_q;
   assign refused_out        = s_q.refused_q;
   assign periph_sel_out     = s_q.psel_q;
   assign occupied_out       = s_q.occ_q;
   assign large_ram_base_out = s_q.lram_base_q;
   assign seg_lines_out      = s_q.seg_lines_q;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   a_flash_user_map: assert property (
      req_valid_in && !write_in && !segment_remap_bit_in && !bootstrap_mode_in
      && addr_in <= 24'h007FFF
      |=> target_out == TGT_FLASH && sector_out == 3'($past(addr_in[14:13])))
      else $error("low flash sector decode wrong");

   a_test_hidden: assert property (
      req_valid_in && !bootstrap_mode_in |=> target_out != TGT_TEST_FLASH)
      else $error("test sector visible in user mode");

   a_boot_fetch_test: assert property (
      req_valid_in && bootstrap_mode_in && fetch_in && addr_in <= 24'h001FFF
      |=> target_out == TGT_TEST_FLASH && width32_out)
      else $error("bootstrap fetch missed test sector");

   a_write_alt_map: assert property (
      req_valid_in && write_in && addr_in >= 24'h010000
      && addr_in <= 24'h017FFF
      |=> target_out == TGT_FLASH
      && offset_out == $past(addr_in[17:0]) - 18'h10000)
      else $error("write not relocated to segment 1");

   a_fetch_width: assert property (
      resp_valid_out && target_out == TGT_FLASH
      |-> width32_out == $past(fetch_in))
      else $error("flash path width wrong");

   a_reserved_area: assert property (
      req_valid_in && addr_in >= 24'h050000 && addr_in <= 24'h07FFFF
      |=> target_out == TGT_RESERVED && refused_out)
      else $error("reserved area not refused");

   a_small_ram_gate: assert property (
      req_valid_in && !s_q.glb_q && addr_in >= 24'h00E000
      && addr_in <= 24'h00E7FF |=> target_out == TGT_EXTERNAL)
      else $error("small RAM decoded while disabled");

   a_ram_zero_wait: assert property (
      resp_valid_out && (target_out == TGT_SMALL_RAM
      || target_out == TGT_LARGE_RAM)
      |-> wait_states_out == 2'h0 && !refused_out)
      else $error("extension RAM access not zero wait");

   a_lram_reset_base: assert property (
      $past(rst_in) |-> large_ram_base_out == 10'h024)
      else $error("large RAM base not at reset value");

   a_periph_timing: assert property (
      resp_valid_out && target_out == TGT_PERIPH
      |-> wait_states_out == 2'h2 && access_cycles_out == 5'h10
      && refused_out == $past(byte_in) && $onehot(periph_sel_out))
      else $error("peripheral access timing wrong");

   a_seg_lines: assert property (
      ##1 (occupied_out[0] || occupied_out[1]) |=> seg_lines_out == 4'h4)
      else $error("segment lines not limited");

   a_late_enable: assert property (
      s_q.glb_q && global_expansion_enable_in
      |=> occupied_out == $past(occupied_out))
      else $error("enables changed while global set");

   a_sector4_map: assert property (
      req_valid_in && addr_in >= 24'h018000 && addr_in <= 24'h01FFFF
      |=> target_out == TGT_FLASH && sector_out == 3'h4)
      else $error("sector four decode wrong");

   a_flash_regs: assert property (
      req_valid_in && addr_in >= 24'h080000 && addr_in <= 24'h08FFFF
      |=> target_out == TGT_FLASH_REGS && !width32_out && !refused_out)
      else $error("flash register area decode wrong");

   a_test_no_write: assert property (
      resp_valid_out && target_out == TGT_TEST_FLASH
      |-> refused_out == $past(write_in))
      else $error("test sector write not refused");

   a_periph_gate: assert property (
      req_valid_in && !s_q.glb_q && addr_in >= 24'h00E800
      && addr_in <= 24'h00EFFF |=> target_out == TGT_EXTERNAL)
      else $error("peripheral decoded while global clear");

   a_resp_pulse: assert property (
      !$past(rst_in) |-> resp_valid_out == $past(req_valid_in))
      else $error("answer not one cycle after request");

   a_occ_clear: assert property (
      !global_expansion_enable_in |=> occupied_out == 11'h000)
      else $error("units occupied while global clear");

   a_large_ram_map: assert property (
      req_valid_in && occupied_out[3] && addr_in >= 24'h090000
      && addr_in[23:14] == large_ram_base_out
      |=> target_out == TGT_LARGE_RAM)
      else $error("large RAM window missed");

   a_msg1_decode: assert property (
      req_valid_in && occupied_out[0] && addr_in[23:8] == 16'h00EF
      |=> target_out == TGT_PERIPH && periph_sel_out == 8'h01)
      else $error("first message controller missed");

   a_rtc_decode: assert property (
      req_valid_in && occupied_out[4] && addr_in[23:8] == 16'h00ED
      |=> target_out == TGT_PERIPH && periph_sel_out == 8'h04)
      else $error("real-time clock page missed");

   a_misc_decode: assert property (
      req_valid_in && occupied_out[10] && addr_in[23:8] == 16'h00EB
      |=> target_out == TGT_PERIPH && periph_sel_out == 8'h80)
      else $error("miscellaneous page missed");

   c_periph_access: cover property (
      resp_valid_out && target_out == TGT_PERIPH && !refused_out);
   c_large_ram: cover property (
      resp_valid_out && target_out == TGT_LARGE_RAM);
   c_boot_test: cover property (
      resp_valid_out && target_out == TGT_TEST_FLASH);
   c_byte_refused: cover property (
      resp_valid_out && target_out == TGT_PERIPH && refused_out);

endmodule : onchip_address_decoder

`default_nettype wire

// File: logic/addr_decoder_cfg.svh
// Purpose: Address map constants for the on-chip address decoder.
// Assumes: 24-bit byte address, 250 MHz core clock.
// Notes:   Definitions only.
`ifndef ADDR_DECODER_CFG_SVH
`define ADDR_DECODER_CFG_SVH

`define CFG_ADDR_W          24
`define CFG_OFS_W           18
`define CFG_FLASH_TOP       24'h04FFFF
`define CFG_SEG1_BASE       24'h010000
`define CFG_LOW_SECT_TOP    24'h007FFF
`define CFG_SECT4_LO        24'h018000
`define CFG_SECT4_HI        24'h01FFFF
`define CFG_TEST_TOP        24'h001FFF
`define CFG_RSVD_LO         24'h050000
`define CFG_RSVD_HI         24'h07FFFF
`define CFG_FREG_LO         24'h080000
`define CFG_FREG_HI         24'h08FFFF
`define CFG_SRAM_LO         24'h00E000
`define CFG_SRAM_HI         24'h00E7FF
`define CFG_LRAM_BASE_RST   10'h024
`define CFG_PG_MSG1         16'h00EF
`define CFG_PG_MSG2         16'h00EE
`define CFG_PG_RTC          16'h00ED
`define CFG_PG_PWM          16'h00EC
`define CFG_PG_ASYNC        16'h00E9
`define CFG_PG_SYNC         16'h00E8
`define CFG_PG_I2C          16'h00EA
`define CFG_PG_MISC         16'h00EB
`define CFG_BIT_MSG1        0
`define CFG_BIT_MSG2        1
`define CFG_BIT_SRAM        2
`define CFG_BIT_LRAM        3
`define CFG_BIT_RTC         4
`define CFG_BIT_PWM         6
`define CFG_BIT_ASYNC       7
`define CFG_BIT_SYNC        8
`define CFG_BIT_I2C         9
`define CFG_BIT_MISC        10
`define CFG_PERIPH_WAIT     2'h2
`define CFG_PERIPH_ACC_PS   62500
`define CFG_CLK_PERIOD_PS   4000
`define CFG_PERIPH_CYCLES   ((`CFG_PERIPH_ACC_PS+`CFG_CLK_PERIOD_PS-1)/`CFG_CLK_PERIOD_PS)
`define CFG_SEG_LINES_FULL  4'h8
`define CFG_SEG_LINES_MSG   4'h4

`endif

// File: logic/addr_decoder_pkg.sv
// Purpose: Types shared by the address decoder files.
// Assumes: Constants come from addr_decoder_cfg.svh.
// Notes:   Types only.
package addr_decoder_pkg;

   typedef enum logic [3:0] {
      TGT_NONE,
      TGT_FLASH,
      TGT_TEST_FLASH,
      TGT_FLASH_REGS,
      TGT_RESERVED,
      TGT_SMALL_RAM,
      TGT_LARGE_RAM,
      TGT_PERIPH,
      TGT_EXTERNAL
   } target_t;

   typedef struct packed {
      logic          glb_q;
      logic [10:0]   occ_q;
      logic [9:0]    lram_base_q;
      logic          valid_q;
      target_t       target_q;
      logic [2:0]    sector_q;
      logic [17:0]   offset_q;
      logic          width32_q;
      logic [1:0]    wait_q;
      logic [4:0]    cycles_q;
      logic          refused_q;
      logic [7:0]    psel_q;
      logic [3:0]    seg_lines_q;
   } state_t;

endpackage : addr_decoder_pkg

// File: logic/range_match.sv
// Purpose: Enabled compare of an address against an inclusive range.
// Assumes: Combinational, same clock domain as the caller.
// Notes:   Used once per expansion peripheral page.
`timescale 1ns/10ps
`default_nettype none

module range_match
(
   input  wire logic [23:0] addr_in,
   input  wire logic [23:0] lo_in,
   input  wire logic [23:0] hi_in,
   input  wire logic        enable_in,
   output logic             hit_out
);

   assign hit_out = enable_in && (addr_in >= lo_in) && (addr_in <= hi_in);

endmodule : range_match

`default_nettype wire

// File: logic/flash_sector_map.sv
// Purpose: Maps an address onto the internal program flash sectors.
// Assumes: alt_map_in already merges write/erase and segment remap.
// Notes:   Offset is the physical byte offset inside the flash array.
`timescale 1ns/10ps
`default_nettype none
`include "addr_decoder_cfg.svh"

module flash_sector_map
(
   input  wire logic [23:0] addr_in,
   input  wire logic        alt_map_in,
   input  wire logic        boot_in,
   input  wire logic        fetch_in,
   output logic             hit_out,
   output logic             test_hit_out,
   output logic [2:0]       sector_out,
   output logic [17:0]      offset_out
);

   logic [23:0] low_base;
   logic [23:0] rel;

   always_comb
   begin
      low_base = alt_map_in ? `CFG_SEG1_BASE : 24'h000000;
      rel = addr_in - low_base;
      hit_out = 1'b0;
      test_hit_out = 1'b0;
      sector_out = 3'h0;
      offset_out = 18'h00000;
      // Test sector only exists in bootstrap, for fetches or the alt map
      if (boot_in && (fetch_in || alt_map_in)
          && addr_in <= `CFG_TEST_TOP)
      begin
         test_hit_out = 1'b1;
         offset_out = addr_in[17:0];
      end
      else if (addr_in >= low_base
               && rel <= `CFG_LOW_SECT_TOP)
      begin
         hit_out = 1'b1;
         sector_out = {1'b0, rel[14:13]};
         offset_out = {3'h0, rel[14:0]};
      end
      else if (addr_in >= `CFG_SECT4_LO
               && addr_in <= `CFG_FLASH_TOP)
      begin
         hit_out = 1'b1;
         offset_out = addr_in[17:0] - 18'h10000;
         if (addr_in <= `CFG_SECT4_HI)
            sector_out = 3'h4;
         else
            sector_out = 3'(addr_in[18:16] + 3'h3);
      end
   end

endmodule : flash_sector_map

`default_nettype wire

// File: test/core_requester.sv
// Purpose: Processor core model that issues one access at a time.
// Assumes: Requests launch 1 ns after a rising edge of clk_in.
// Notes:   Released fields show the inverse of the last request, so a
//          decoder that samples outside the pulse sees a wrong value.
`timescale 1ns/10ps
`default_nettype none

module core_requester
(
   input  wire logic        clk_in,
   output var  logic        req_valid_out,
   output var  logic [23:0] addr_out,
   output var  logic        write_out,
   output var  logic        byte_out,
   output var  logic        fetch_out
);
   initial
   begin
      req_valid_out = 1'b0;
      addr_out      = 24'h000000;
      write_out     = 1'b0;
      byte_out      = 1'b0;
      fetch_out     = 1'b0;
   end

   // One-cycle pulse, fields held until the taking edge has passed
   task automatic issue(input logic [23:0] a, input logic wr,
                        input logic by, input logic ft);
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b1;
      addr_out      = a;
      write_out     = wr;
      byte_out      = by;
      fetch_out     = ft;
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b0;
      addr_out      = ~a;
      write_out     = ~wr;
      byte_out      = ~by;
      fetch_out     = ~ft;
   endtask : issue
endmodule : core_requester

`default_nettype wire

// File: test/onchip_address_decoder_tb.sv
// Purpose: Self-checking bench for the on-chip address decoder.
// Assumes: Large variant; the core model sends one access at a time.
// Notes:   Answers are sampled 1 ns after the edge that takes them.
`timescale 1ns/10ps
`default_nettype none

module onchip_address_decoder_tb import addr_decoder_pkg::*;;
   logic        clk_sys_in;
   logic        rst_in;
   logic        req_valid;
   logic [23:0] addr;
   logic        write_req;
   logic        byte_req;
   logic        fetch_req;
   logic        boot;
   logic        remap;
   logic        glb;
   logic [15:0] ctrl;
   logic        base_we;
   logic [9:0]  base_sel;
   logic        resp_valid;
   target_t     target;
   logic [2:0]  sector;
   logic [17:0] offset;
   logic        width32;
   logic [1:0]  waits;
   logic [4:0]  cycles;
   logic        refused;
   logic [7:0]  psel;
   logic [10:0] occ;
   logic [9:0]  base;
   logic [3:0]  seg;
   int          errors;
   int          n_tests;
   logic [23:0] pg [8];

   core_requester core (.clk_in(clk_sys_in), .req_valid_out(req_valid),
      .addr_out(addr), .write_out(write_req), .byte_out(byte_req),
      .fetch_out(fetch_req));

   onchip_address_decoder #(.LARGE_VARIANT(1'b1)) uut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(req_valid),
      .addr_in(addr), .write_in(write_req), .byte_in(byte_req),
      .fetch_in(fetch_req), .bootstrap_mode_in(boot),
      .segment_remap_bit_in(remap), .global_expansion_enable_in(glb),
      .expansion_periph_control_in(ctrl), .large_ram_base_we_in(base_we),
      .large_ram_base_select_in(base_sel), .resp_valid_out(resp_valid),
      .target_out(target), .sector_out(sector), .offset_out(offset),
      .width32_out(width32), .wait_states_out(waits),
      .access_cycles_out(cycles), .refused_out(refused),
      .periph_sel_out(psel), .occupied_out(occ),
      .large_ram_base_out(base), .seg_lines_out(seg));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task automatic stop_test;
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t ns: got %h expected %h",
                  $time, got, exp);
      end
   endtask : chk

   // Flags are {write, byte, fetch}; peripherals cost 2 waits, 16 cycles
   task automatic acc(input logic [23:0] a, input logic [2:0] wbf,
                      input target_t t, input logic [2:0] s,
                      input logic w32, input logic rf);
      core.issue(a, wbf[2], wbf[1], wbf[0]);
      chk(32'(resp_valid), 32'h1);
      chk(32'(target), 32'(t));
      if (t == TGT_FLASH)
         chk(32'(sector), 32'(s));
      chk(32'(width32), 32'(w32));
      chk(32'(waits), (t == TGT_PERIPH) ? 32'h2 : 32'h0);
      chk(32'(cycles), (t == TGT_PERIPH) ? 32'h10 : 32'h1);
      chk(32'(refused), 32'(rf));
   endtask : acc

   // Occupancy shows one edge after the global rise, segment lines two
   task automatic set_en(input logic [15:0] c, input logic g);
      @(posedge clk_sys_in);
      #1;
      ctrl = c;
      glb  = g;
      repeat (2) @(posedge clk_sys_in);
      #1;
   endtask : set_en

   initial
   begin
      #100000;
      errors++;
      stop_test();
   end

   initial
   begin
      pg = '{24'h00EF10, 24'h00EE10, 24'h00ED10, 24'h00EC10,
             24'h00E910, 24'h00E810, 24'h00EA10, 24'h00EB10};
      errors = 0;
      n_tests = 0;
      rst_in = 1'b1;
      boot = 1'b0;
      remap = 1'b0;
      glb = 1'b0;
      ctrl = 16'h0000;
      base_we = 1'b0;
      base_sel = 10'h000;
      repeat (16) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
      chk(32'(base), 32'h024);
      chk(32'(seg), 32'h8);
      chk(32'(occ), 32'h000);
      acc(24'h000000, 3'h1, TGT_FLASH, 3'h0, 1'b1, 1'b0);
      acc(24'h006000, 3'h2, TGT_FLASH, 3'h3, 1'b0, 1'b0);
      @(posedge clk_sys_in);
      #1;
      chk(32'(resp_valid), 32'h0);
      acc(24'h018000, 3'h1, TGT_FLASH, 3'h4, 1'b1, 1'b0);
      chk(32'(offset), 32'h08000);
      acc(24'h020000, 3'h0, TGT_FLASH, 3'h5, 1'b0, 1'b0);
      acc(24'h04FFFF, 3'h2, TGT_FLASH, 3'h7, 1'b0, 1'b0);
      chk(32'(offset), 32'h3FFFF);
      acc(24'h008000, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      acc(24'h016000, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      acc(24'h016000, 3'h4, TGT_FLASH, 3'h3, 1'b0, 1'b0);
      chk(32'(offset), 32'h06000);
      acc(24'h050000, 3'h0, TGT_RESERVED, 3'h0, 1'b0, 1'b1);
      acc(24'h07FFFF, 3'h2, TGT_RESERVED, 3'h0, 1'b0, 1'b1);
      acc(24'h080000, 3'h1, TGT_FLASH_REGS, 3'h0, 1'b0, 1'b0);
      acc(24'h08FFFF, 3'h6, TGT_FLASH_REGS, 3'h0, 1'b0, 1'b0);
      remap = 1'b1;
      acc(24'h010000, 3'h0, TGT_FLASH, 3'h0, 1'b0, 1'b0);
      remap = 1'b0;
      boot = 1'b1;
      acc(24'h000000, 3'h1, TGT_TEST_FLASH, 3'h0, 1'b1, 1'b0);
      acc(24'h000100, 3'h4, TGT_TEST_FLASH, 3'h0, 1'b0, 1'b1);
      acc(24'h000000, 3'h0, TGT_FLASH, 3'h0, 1'b0, 1'b0);
      boot = 1'b0;
      acc(24'h00EF10, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      acc(24'h00E000, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      set_en(16'h07DF, 1'b1);
      chk(32'(occ), 32'h7DF);
      chk(32'(seg), 32'h4);
      for (int i = 0; i < 8; i++)
      begin
         acc(pg[i], 3'h0, TGT_PERIPH, 3'h0, 1'b0, 1'b0);
         chk(32'(psel), 32'h1 << i);
         chk(32'(offset), 32'h10);
      end
      acc(24'h00EC10, 3'h6, TGT_PERIPH, 3'h0, 1'b0, 1'b1);
      acc(24'h00E900, 3'h2, TGT_PERIPH, 3'h0, 1'b0, 1'b1);
      acc(24'h00E7FF, 3'h6, TGT_SMALL_RAM, 3'h0, 1'b0, 1'b0);
      chk(32'(offset), 32'h7FF);
      acc(24'h093FFF, 3'h0, TGT_LARGE_RAM, 3'h0, 1'b0, 1'b0);
      chk(32'(offset), 32'h3FFF);
      @(posedge clk_sys_in);
      #1;
      base_we = 1'b1;
      base_sel = 10'h030;
      @(posedge clk_sys_in);
      #1;
      base_we = 1'b0;
      base_sel = 10'h3CF;
      chk(32'(base), 32'h030);
      acc(24'h0C0002, 3'h6, TGT_LARGE_RAM, 3'h0, 1'b0, 1'b0);
      acc(24'h090000, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      set_en(16'h0000, 1'b1);
      chk(32'(occ), 32'h7DF);
      set_en(16'h0000, 1'b0);
      chk(32'(occ), 32'h000);
      acc(24'h0C0002, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      acc(24'h00E000, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      // Enables raised only after the global rise must stay unoccupied
      set_en(16'h0004, 1'b1);
      set_en(16'h0005, 1'b1);
      chk(32'(seg), 32'h8);
      acc(24'h00EF10, 3'h0, TGT_EXTERNAL, 3'h0, 1'b0, 1'b0);
      acc(24'h00E000, 3'h2, TGT_SMALL_RAM, 3'h0, 1'b0, 1'b0);
      // Mid-run reset must restore the base and drop all occupancy
      @(posedge clk_sys_in);
      #1;
      rst_in = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
      chk(32'(base), 32'h024);
      chk(32'(occ), 32'h000);
      chk(32'(seg), 32'h8);
      chk(32'(target), 32'(TGT_NONE));
      stop_test();
   end
endmodule : onchip_address_decoder_tb

`default_nettype wire
